/* inc/lcfg_pkg.sv */
package lcfg_pkg;
    localparam int unsigned AXI_AW = 13;
    localparam int unsigned IRQ_PINS = 16;
    localparam int unsigned DMA_PINS = 4;
    localparam int unsigned N_LD = 4;
    localparam int unsigned IRQ_SEL_W = 4;
    localparam int unsigned DMA_SEL_W = 3;
    // byte address: page in [12:10], register index in [9:2]
    localparam int unsigned PAGE_LSB = 10;
    localparam int unsigned IDX_LSB = 2;
    localparam logic [2:0] PG_FDD = 3'h0;
    localparam logic [2:0] PG_PP = 3'h1;
    localparam logic [2:0] PG_SER1 = 3'h2;
    localparam logic [2:0] PG_SER2 = 3'h3;
    localparam logic [2:0] PG_LOCAL = 3'h4;
    localparam logic [7:0] IDX_ACTIVATE = 8'h30;
    localparam logic [7:0] IDX_IRQ_SEL = 8'h70;
    localparam logic [7:0] IDX_DMA_SEL = 8'h74;
    localparam logic [7:0] IDX_MODE = 8'hF0;
    localparam logic [7:0] IDX_OPT = 8'hF1;
    localparam logic [7:0] IDX_TYPES = 8'hF2;
    localparam logic [7:0] IDX_RSVD_F3 = 8'hF3;
    localparam logic [7:0] IDX_DRV0 = 8'hF4;
    localparam logic [7:0] IDX_DRV1 = 8'hF5;
    localparam logic [7:0] IDX_GATES = 8'h00;
    localparam logic [7:0] IDX_STATUS = 8'h01;
    localparam logic [7:0] FDD_MODE_RST = 8'h0E;
    localparam logic [7:0] FDD_OPT_RST = 8'h00;
    localparam logic [7:0] FDD_TYPES_RST = 8'hFF;
    localparam logic [7:0] DRV_RST = 8'h00;
    localparam logic [7:0] PP_MODE_RST = 8'h3C;
    localparam logic [7:0] PP_MODE2_RST = 8'h00;
    localparam logic [7:0] SER1_MODE_RST = 8'h00;
    localparam logic [3:0] IRQ_SEL_RST = 4'h0;
    localparam logic [2:0] DMA_SEL_RST = 3'h4;
    localparam logic [7:0] FDD_MODE_MASK = 8'hCF;
    localparam logic [7:0] DRV_MASK = 8'h5B;
    localparam logic [7:0] SER1_MODE_MASK = 8'h83;
    localparam int unsigned FM_PUSH_PULL_BIT = 6;
    localparam int unsigned FM_TRISTATE_BIT = 7;
    localparam int unsigned PM_PULSE_BIT = 7;
    localparam int unsigned S1_SHARE_BIT = 7;
    localparam logic [1:0] MUX_DRIVE0 = 2'h1;
    localparam logic [2:0] PPM_PRINTER = 3'h4;
    localparam logic [2:0] PPM_SPP = 3'h0;
    localparam logic [2:0] XM_FIFO = 3'h2;
    localparam logic [2:0] XM_EXT = 3'h3;
    localparam logic [2:0] XM_TEST = 3'h6;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic activate;
        logic [IRQ_SEL_W-1:0] irq_sel;
        logic [DMA_SEL_W-1:0] dma_sel;
    } lcfg_ld_s;

    typedef struct packed {
        logic [2:0] ext_mode;
        logic extended_port_dma_gate;
        logic printer_irq_gate;
        logic [1:0] modem_aux_irq_gate;
        logic fdc_powerdown;
        logic floppy_dma_gate;
    } lcfg_gates_s;

    typedef struct packed {
        logic [7:0] fdd_mode;
        logic [7:0] fdd_opt;
        logic [7:0] fdd_types;
        logic [7:0] drv0;
        logic [7:0] drv1;
        logic [7:0] pp_mode;
        logic [7:0] pp_mode2;
        logic [7:0] s1_mode;
    } lcfg_cfg_s;

    localparam lcfg_ld_s LD_RST = '{activate: 1'b0, irq_sel: IRQ_SEL_RST, dma_sel: DMA_SEL_RST};
    localparam lcfg_cfg_s CFG_RST = '{fdd_mode: FDD_MODE_RST, fdd_opt: FDD_OPT_RST,
        fdd_types: FDD_TYPES_RST, drv0: DRV_RST, drv1: DRV_RST, pp_mode: PP_MODE_RST,
        pp_mode2: PP_MODE2_RST, s1_mode: SER1_MODE_RST};

    typedef struct packed {
        logic awvalid;
        logic [AXI_AW-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [AXI_AW-1:0] araddr;
        logic rready;
    } lcfg_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } lcfg_axi_rsp_s;

    typedef struct packed {
        logic wr;
        logic [AXI_AW-1:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic rd;
        logic [AXI_AW-1:0] raddr;
    } lcfg_rbus_s;
endpackage

/* logic/lcfg_pin_router.sv */
`timescale 1ns/1ns
module lcfg_pin_router #(
    parameter int unsigned N_SRC = 4,
    parameter int unsigned SEL_W = 4,
    parameter int unsigned N_PIN = 16
) (
    input wire logic [N_SRC-1:0] en_i,
    input wire logic [N_SRC-1:0] req_i,
    input wire logic [N_SRC*SEL_W-1:0] sel_i,
    output logic [N_PIN-1:0] val_o,
    output logic [N_PIN-1:0] oe_o
);
    // pin 0 stands for "none selected" and is never driven
    always_comb begin
        val_o = '0;
        oe_o = '0;
        for (int p = 1; p < int'(N_PIN); p++) begin
            for (int i = 0; i < int'(N_SRC); i++) begin
                if (en_i[i] && sel_i[i*SEL_W +: SEL_W] == SEL_W'(p)) begin
                    oe_o[p] = 1'b1;
                    val_o[p] = val_o[p] | req_i[i];
                end
            end
        end
    end
endmodule

/* logic/lcfg_axil_slave.sv */
`timescale 1ns/1ns
module lcfg_axil_slave (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire lcfg_pkg::lcfg_axi_req_s axi_req_i,
    output lcfg_pkg::lcfg_axi_rsp_s axi_rsp_o,
    output lcfg_pkg::lcfg_rbus_s rbus_o,
    input wire logic [31:0] rd_data_i,
    input wire logic wr_hit_i,
    input wire logic rd_hit_i
);
    typedef struct packed {
        logic aw_held;
        logic [lcfg_pkg::AXI_AW-1:0] awaddr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic rd_pend;
        logic [lcfg_pkg::AXI_AW-1:0] araddr;
        lcfg_pkg::lcfg_axi_rsp_s rsp;
    } lcfg_slv_s;

    lcfg_slv_s s_ff;
    lcfg_slv_s nxt_s;

    assign axi_rsp_o = s_ff.rsp;

    always_comb begin
        nxt_s = s_ff;
        rbus_o = '0;
        if (axi_req_i.awvalid && s_ff.rsp.awready) begin
            nxt_s.aw_held = 1'b1;
            nxt_s.awaddr = axi_req_i.awaddr;
        end
        if (axi_req_i.wvalid && s_ff.rsp.wready) begin
            nxt_s.w_held = 1'b1;
            nxt_s.wdata = axi_req_i.wdata;
            nxt_s.wstrb = axi_req_i.wstrb;
        end
        if (s_ff.rsp.bvalid && axi_req_i.bready) begin
            nxt_s.rsp.bvalid = 1'b0;
        end
        if (s_ff.aw_held && s_ff.w_held && !s_ff.rsp.bvalid) begin
            rbus_o.wr = 1'b1;
            rbus_o.waddr = s_ff.awaddr;
            rbus_o.wdata = s_ff.wdata;
            rbus_o.wstrb = s_ff.wstrb;
            nxt_s.aw_held = 1'b0;
            nxt_s.w_held = 1'b0;
            nxt_s.rsp.bvalid = 1'b1;
            nxt_s.rsp.bresp = wr_hit_i ? lcfg_pkg::RESP_OKAY : lcfg_pkg::RESP_SLVERR;
        end
        if (axi_req_i.arvalid && s_ff.rsp.arready) begin
            nxt_s.rd_pend = 1'b1;
            nxt_s.araddr = axi_req_i.araddr;
        end
        if (s_ff.rsp.rvalid && axi_req_i.rready) begin
            nxt_s.rsp.rvalid = 1'b0;
        end
        if (s_ff.rd_pend) begin
            rbus_o.rd = 1'b1;
            rbus_o.raddr = s_ff.araddr;
            nxt_s.rd_pend = 1'b0;
            nxt_s.rsp.rvalid = 1'b1;
            nxt_s.rsp.rdata = rd_data_i;
            nxt_s.rsp.rresp = rd_hit_i ? lcfg_pkg::RESP_OKAY : lcfg_pkg::RESP_SLVERR;
        end
        // one transaction per channel pair in flight: at most one write and one read reach the register file per cycle
        nxt_s.rsp.awready = !nxt_s.aw_held && !nxt_s.rsp.bvalid;
        nxt_s.rsp.wready = !nxt_s.w_held && !nxt_s.rsp.bvalid;
        nxt_s.rsp.arready = !nxt_s.rd_pend && !nxt_s.rsp.rvalid;
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end
endmodule

/* logic/lcfg_top.sv */
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ns
// Operation
// - local enable bits also silence outputs
// - floppy gate low: irq, ack float
// - floppy powered down: outputs float
// - serial aux bit low: irq floats
// - printer irq gate low: irq floats
// - extended port: gated dma; ext mode 2, 3, 6 fixes irq on
// - only hard reset restores config; soft reset clears gates
// - floppy bits 3:2 pick interface variant
// - floppy pin drive type and tristate
// - drive type register resets all ones
// - floppy index 0xF3 reads zero
// - per-drive registers, fixed zero bits
// - parallel mode resets 0x3C, mode bits
// - threshold field resets to 0111
// - bit 7 picks pulsed or level irq
// - mode two bits 1:0 mux floppy
// - serial mode resets zero, reserved zero
// - share bit: both serial pins assert
// - unselected request pins float
// - irq needs nonzero select and enable
module lcfg_top (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic soft_rst_i,
    input wire lcfg_pkg::lcfg_axi_req_s s_axi_req_i,
    output lcfg_pkg::lcfg_axi_rsp_s s_axi_rsp_o,
    input wire logic fdc_irq_req_i,
    input wire logic fdc_drq_i,
    input wire logic pp_irq_req_i,
    input wire logic pp_ack_n_i,
    input wire logic pp_drq_i,
    input wire logic ser1_irq_req_i,
    input wire logic ser2_irq_req_i,
    output logic [lcfg_pkg::IRQ_PINS-1:0] irq_o,
    output logic [lcfg_pkg::IRQ_PINS-1:0] irq_oe_o,
    output logic [lcfg_pkg::DMA_PINS-1:0] drq_o,
    output logic [lcfg_pkg::DMA_PINS-1:0] drq_oe_o,
    output logic fdc_dack_en_o,
    output logic pp_dack_en_o,
    output logic fdd_push_pull_o,
    output logic fdd_tristate_o,
    output logic drive0_on_floppy_pins_o,
    output lcfg_pkg::lcfg_cfg_s cfg_o
);
    typedef struct packed {
        lcfg_pkg::lcfg_ld_s [lcfg_pkg::N_LD-1:0] ld;
        lcfg_pkg::lcfg_cfg_s cfg;
        lcfg_pkg::lcfg_gates_s gates;
        logic pp_src_d;
        logic pp_pulse;
        logic [lcfg_pkg::IRQ_PINS-1:0] irq;
        logic [lcfg_pkg::IRQ_PINS-1:0] irq_oe;
        logic [lcfg_pkg::DMA_PINS-1:0] drq;
        logic [lcfg_pkg::DMA_PINS-1:0] drq_oe;
        logic [1:0] dack_en;
        logic fdd_push_pull;
        logic fdd_tristate;
        logic drive0_on_floppy_pins;
    } lcfg_top_s;

    lcfg_top_s s_ff;
    lcfg_top_s nxt_s;

    lcfg_pkg::lcfg_rbus_s rbus;
    logic [32:0] rd_look;
    logic [32:0] wr_look;

    // bit 32 of the result is the address hit, bits 31:0 the read data
    function automatic logic [32:0] reg_access(
        input lcfg_top_s st,
        input logic [lcfg_pkg::AXI_AW-1:0] a
    );
        logic [2:0] pg;
        logic [7:0] idx;
        logic [31:0] d;
        logic hit;
        logic is_ld;
        pg = a[lcfg_pkg::PAGE_LSB +: 3];
        idx = a[lcfg_pkg::IDX_LSB +: 8];
        d = '0;
        hit = 1'b1;
        is_ld = pg < 3'(lcfg_pkg::N_LD);
        if (is_ld && idx == lcfg_pkg::IDX_ACTIVATE) begin
            d[0] = st.ld[pg[1:0]].activate;
        end else if (is_ld && idx == lcfg_pkg::IDX_IRQ_SEL) begin
            d[lcfg_pkg::IRQ_SEL_W-1:0] = st.ld[pg[1:0]].irq_sel;
        end else if (is_ld && idx == lcfg_pkg::IDX_DMA_SEL) begin
            d[lcfg_pkg::DMA_SEL_W-1:0] = st.ld[pg[1:0]].dma_sel;
        end else begin
            case ({pg, idx})
                {lcfg_pkg::PG_FDD, lcfg_pkg::IDX_MODE}: d[7:0] = st.cfg.fdd_mode;
                {lcfg_pkg::PG_FDD, lcfg_pkg::IDX_OPT}: d[7:0] = st.cfg.fdd_opt;
                {lcfg_pkg::PG_FDD, lcfg_pkg::IDX_TYPES}: d[7:0] = st.cfg.fdd_types;
                {lcfg_pkg::PG_FDD, lcfg_pkg::IDX_RSVD_F3}: d = '0;
                {lcfg_pkg::PG_FDD, lcfg_pkg::IDX_DRV0}: d[7:0] = st.cfg.drv0;
                {lcfg_pkg::PG_FDD, lcfg_pkg::IDX_DRV1}: d[7:0] = st.cfg.drv1;
                {lcfg_pkg::PG_PP, lcfg_pkg::IDX_MODE}: d[7:0] = st.cfg.pp_mode;
                {lcfg_pkg::PG_PP, lcfg_pkg::IDX_OPT}: d[7:0] = st.cfg.pp_mode2;
                {lcfg_pkg::PG_SER1, lcfg_pkg::IDX_MODE}: d[7:0] = st.cfg.s1_mode;
                {lcfg_pkg::PG_LOCAL, lcfg_pkg::IDX_GATES}: d[8:0] = st.gates;
                {lcfg_pkg::PG_LOCAL, lcfg_pkg::IDX_STATUS}: begin
                    d[21:0] = {st.dack_en, st.drq_oe, st.irq_oe};
                end
                default: hit = 1'b0;
            endcase
        end
        return {hit, d};
    endfunction

    // a channel code outside 1..3 means no channel, so no acknowledge either
    function automatic logic dma_ok(input logic [lcfg_pkg::DMA_SEL_W-1:0] sel);
        return (sel != '0) && (sel < lcfg_pkg::DMA_SEL_W'(lcfg_pkg::DMA_PINS));
    endfunction

    assign rd_look = reg_access(s_ff, rbus.raddr);
    assign wr_look = reg_access(s_ff, rbus.waddr);

    lcfg_axil_slave u_slave (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .axi_req_i(s_axi_req_i),
        .axi_rsp_o(s_axi_rsp_o),
        .rbus_o(rbus),
        .rd_data_i(rd_look[31:0]),
        .wr_hit_i(wr_look[32]),
        .rd_hit_i(rd_look[32])
    );

    // gating and request terms: enables from registered state, requests from the live inputs
    logic fdd_on;
    logic pp_ext;
    logic pp_std;
    logic xm_irq_on;
    logic pp_irq_gate;
    logic pp_irq_en;
    logic pp_dma_en;
    logic pulse_mode;
    logic ack_follow;
    logic pp_src;
    logic pp_pin_en;
    logic pp_pin_req;
    logic ser1_g;
    logic ser2_g;
    logic ser_share;
    logic ser1_req;
    logic ser2_req;
    logic ser1_en;
    logic ser2_en;
    logic [lcfg_pkg::IRQ_PINS-1:0] irq_val;
    logic [lcfg_pkg::IRQ_PINS-1:0] irq_oe;
    logic [lcfg_pkg::DMA_PINS-1:0] drq_val;
    logic [lcfg_pkg::DMA_PINS-1:0] drq_oe;

    assign fdd_on = s_ff.ld[0].activate && s_ff.gates.floppy_dma_gate
        && !s_ff.gates.fdc_powerdown;

    // extended-capability family: port modes 010, 011, 110 and 111
    assign pp_ext = s_ff.cfg.pp_mode[1];
    assign pp_std = (s_ff.cfg.pp_mode[2:0] == lcfg_pkg::PPM_PRINTER)
        || (s_ff.cfg.pp_mode[2:0] == lcfg_pkg::PPM_SPP);
    assign xm_irq_on = (s_ff.gates.ext_mode == lcfg_pkg::XM_FIFO)
        || (s_ff.gates.ext_mode == lcfg_pkg::XM_EXT)
        || (s_ff.gates.ext_mode == lcfg_pkg::XM_TEST);
    assign pp_irq_gate = (pp_ext && xm_irq_on) ? 1'b1 : s_ff.gates.printer_irq_gate;
    assign pp_irq_en = s_ff.ld[1].activate && pp_irq_gate;
    assign pp_dma_en = s_ff.ld[1].activate && pp_ext && s_ff.gates.extended_port_dma_gate;

    assign pulse_mode = s_ff.cfg.pp_mode[lcfg_pkg::PM_PULSE_BIT] && !pp_std;
    assign ack_follow = pp_ext ? !xm_irq_on : !pp_std;
    assign pp_src = (ack_follow && !pp_std) ? pp_ack_n_i : pp_irq_req_i;
    // a pulse is a low drive for one cycle, then the pin is let go
    assign pp_pin_en = pp_irq_en && (pulse_mode ? s_ff.pp_pulse : 1'b1);
    assign pp_pin_req = pulse_mode ? 1'b0 : pp_src;

    assign ser1_g = ser1_irq_req_i && s_ff.gates.modem_aux_irq_gate[0];
    assign ser2_g = ser2_irq_req_i && s_ff.gates.modem_aux_irq_gate[1];
    assign ser1_en = s_ff.ld[2].activate && s_ff.gates.modem_aux_irq_gate[0];
    assign ser2_en = s_ff.ld[3].activate && s_ff.gates.modem_aux_irq_gate[1];
    assign ser_share = s_ff.cfg.s1_mode[lcfg_pkg::S1_SHARE_BIT];
    assign ser1_req = ser_share ? (ser1_g || ser2_g) : ser1_g;
    assign ser2_req = ser_share ? (ser1_g || ser2_g) : ser2_g;

    lcfg_pin_router #(
        .N_SRC(4),
        .SEL_W(lcfg_pkg::IRQ_SEL_W),
        .N_PIN(lcfg_pkg::IRQ_PINS)
    ) u_irq_route (
        .en_i({ser2_en, ser1_en, pp_pin_en, fdd_on}),
        .req_i({ser2_req, ser1_req, pp_pin_req, fdc_irq_req_i}),
        .sel_i({s_ff.ld[3].irq_sel, s_ff.ld[2].irq_sel, s_ff.ld[1].irq_sel,
            s_ff.ld[0].irq_sel}),
        .val_o(irq_val),
        .oe_o(irq_oe)
    );

    lcfg_pin_router #(
        .N_SRC(2),
        .SEL_W(lcfg_pkg::DMA_SEL_W),
        .N_PIN(lcfg_pkg::DMA_PINS)
    ) u_dma_route (
        .en_i({pp_dma_en, fdd_on}),
        .req_i({pp_drq_i, fdc_drq_i}),
        .sel_i({s_ff.ld[1].dma_sel, s_ff.ld[0].dma_sel}),
        .val_o(drq_val),
        .oe_o(drq_oe)
    );

    logic [2:0] wpg;
    logic [7:0] widx;
    logic [7:0] wb;
    logic w0;

    assign wpg = rbus.waddr[lcfg_pkg::PAGE_LSB +: 3];
    assign widx = rbus.waddr[lcfg_pkg::IDX_LSB +: 8];
    assign wb = rbus.wdata[7:0];
    assign w0 = rbus.wr && wr_look[32] && rbus.wstrb[0];

    always_comb begin
        nxt_s = s_ff;
        // output stage: one register after the routers
        nxt_s.irq = irq_val;
        nxt_s.irq_oe = irq_oe;
        nxt_s.drq = drq_val;
        nxt_s.drq_oe = drq_oe;
        nxt_s.dack_en[0] = fdd_on && dma_ok(s_ff.ld[0].dma_sel);
        nxt_s.dack_en[1] = pp_dma_en && dma_ok(s_ff.ld[1].dma_sel);
        nxt_s.pp_src_d = pp_src;
        nxt_s.pp_pulse = pulse_mode && pp_irq_en && pp_src && !s_ff.pp_src_d;
        nxt_s.fdd_push_pull = s_ff.cfg.fdd_mode[lcfg_pkg::FM_PUSH_PULL_BIT];
        nxt_s.fdd_tristate = s_ff.cfg.fdd_mode[lcfg_pkg::FM_TRISTATE_BIT];
        nxt_s.drive0_on_floppy_pins = s_ff.cfg.pp_mode2[1:0] == lcfg_pkg::MUX_DRIVE0;

        if (w0 && wpg < 3'(lcfg_pkg::N_LD)) begin
            case (widx)
                lcfg_pkg::IDX_ACTIVATE: nxt_s.ld[wpg[1:0]].activate = wb[0];
                lcfg_pkg::IDX_IRQ_SEL: begin
                    nxt_s.ld[wpg[1:0]].irq_sel = wb[lcfg_pkg::IRQ_SEL_W-1:0];
                end
                lcfg_pkg::IDX_DMA_SEL: begin
                    nxt_s.ld[wpg[1:0]].dma_sel = wb[lcfg_pkg::DMA_SEL_W-1:0];
                end
                default: ;
            endcase
        end
        if (w0) begin
            case ({wpg, widx})
                {lcfg_pkg::PG_FDD, lcfg_pkg::IDX_MODE}: begin
                    nxt_s.cfg.fdd_mode = wb & lcfg_pkg::FDD_MODE_MASK;
                end
                {lcfg_pkg::PG_FDD, lcfg_pkg::IDX_OPT}: nxt_s.cfg.fdd_opt = wb;
                {lcfg_pkg::PG_FDD, lcfg_pkg::IDX_TYPES}: nxt_s.cfg.fdd_types = wb;
                {lcfg_pkg::PG_FDD, lcfg_pkg::IDX_DRV0}: begin
                    nxt_s.cfg.drv0 = wb & lcfg_pkg::DRV_MASK;
                end
                {lcfg_pkg::PG_FDD, lcfg_pkg::IDX_DRV1}: begin
                    nxt_s.cfg.drv1 = wb & lcfg_pkg::DRV_MASK;
                end
                {lcfg_pkg::PG_PP, lcfg_pkg::IDX_MODE}: nxt_s.cfg.pp_mode = wb;
                {lcfg_pkg::PG_PP, lcfg_pkg::IDX_OPT}: nxt_s.cfg.pp_mode2 = wb;
                {lcfg_pkg::PG_SER1, lcfg_pkg::IDX_MODE}: begin
                    nxt_s.cfg.s1_mode = wb & lcfg_pkg::SER1_MODE_MASK;
                end
                {lcfg_pkg::PG_LOCAL, lcfg_pkg::IDX_GATES}: nxt_s.gates[7:0] = wb;
                default: ;
            endcase
        end
        if (rbus.wr && wr_look[32] && rbus.wstrb[1]
                && wpg == lcfg_pkg::PG_LOCAL && widx == lcfg_pkg::IDX_GATES) begin
            nxt_s.gates[8] = rbus.wdata[8];
        end

        // soft reset spares configuration
        // the gate bits mirror the function blocks, which a soft reset does clear
        if (soft_rst_i) begin
            nxt_s.gates = '0;
            nxt_s.pp_pulse = 1'b0;
            nxt_s.pp_src_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_ff <= '0;
            s_ff.ld <= {lcfg_pkg::N_LD{lcfg_pkg::LD_RST}};
            s_ff.cfg <= lcfg_pkg::CFG_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign irq_o = s_ff.irq;
    assign irq_oe_o = s_ff.irq_oe;
    assign drq_o = s_ff.drq;
    assign drq_oe_o = s_ff.drq_oe;
    assign fdc_dack_en_o = s_ff.dack_en[0];
    assign pp_dack_en_o = s_ff.dack_en[1];
    assign fdd_push_pull_o = s_ff.fdd_push_pull;
    assign fdd_tristate_o = s_ff.fdd_tristate;
    assign drive0_on_floppy_pins_o = s_ff.drive0_on_floppy_pins;
    assign cfg_o = s_ff.cfg;
endmodule

/* bench/lcfg_chk.sv */
`timescale 1ns/1ns
module lcfg_chk (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic soft_rst_i,
    input wire lcfg_pkg::lcfg_axi_rsp_s s_axi_rsp_o,
    input wire logic [lcfg_pkg::IRQ_PINS-1:0] irq_oe_o,
    input wire logic [lcfg_pkg::DMA_PINS-1:0] drq_oe_o,
    input wire logic fdd_push_pull_o,
    input wire logic fdd_tristate_o,
    input wire logic drive0_on_floppy_pins_o,
    input wire lcfg_pkg::lcfg_cfg_s cfg_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    a_push_pull: assert property (fdd_push_pull_o == $past(cfg_o.fdd_mode[6]))
        else $error("push-pull pin off mode");
    a_tristate_pin: assert property (fdd_tristate_o == $past(cfg_o.fdd_mode[7]))
        else $error("tristate pin off mode");
    a_mux_pin: assert property (drive0_on_floppy_pins_o
        == ($past(cfg_o.pp_mode2[1:0]) == 2'h1))
        else $error("mux pin off mode two");
    a_unused_pins: assert property (!irq_oe_o[0] && !drq_oe_o[0])
        else $error("pin zero driven");
    a_serial_rsvd: assert property (cfg_o.s1_mode[6:2] == 5'h00)
        else $error("serial reserved bits set");
    a_drive_rsvd: assert property (
        ((cfg_o.drv0 | cfg_o.drv1) & ~lcfg_pkg::DRV_MASK) == 8'h00)
        else $error("drive reserved bits set");
    a_fdd_rsvd: assert property (cfg_o.fdd_mode[5:4] == 2'h0)
        else $error("floppy reserved bits set");
    // no write can land in the next cycle while both readies are up
    a_soft_keeps: assert property (
        soft_rst_i && s_axi_rsp_o.awready && s_axi_rsp_o.wready |=> $stable(cfg_o))
        else $error("soft reset touched config");
endmodule
bind lcfg_top lcfg_chk u_chk (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .soft_rst_i(soft_rst_i),
    .s_axi_rsp_o(s_axi_rsp_o), .irq_oe_o(irq_oe_o), .drq_oe_o(drq_oe_o),
    .fdd_push_pull_o(fdd_push_pull_o), .fdd_tristate_o(fdd_tristate_o),
    .drive0_on_floppy_pins_o(drive0_on_floppy_pins_o), .cfg_o(cfg_o));

/* bench/lcfg_host.sv */
`timescale 1ns/1ns
module lcfg_host (
    input wire logic clk_sys_i,
    output lcfg_pkg::lcfg_axi_req_s req_o,
    input wire lcfg_pkg::lcfg_axi_rsp_s rsp_i
);
    initial req_o = '0;
    task automatic hang(input int n);
        if (n < 64) return;
        tb.err_count++;
        tb.give_verdict();
    endtask
    task automatic wr(input logic [12:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        req_o.awaddr <= a;
        req_o.wdata <= d;
        req_o.wstrb <= 4'h3;
        {req_o.awvalid, req_o.wvalid, req_o.bready} <= 3'h7;
        // address and data may be taken at different edges
        do begin
            @(posedge clk_sys_i);
            n++;
            if (rsp_i.awready) req_o.awvalid <= 1'b0;
            if (rsp_i.wready) req_o.wvalid <= 1'b0;
        end while (!rsp_i.bvalid && n < 64);
        req_o.bready <= 1'b0;
        hang(n);
    endtask
    task automatic rd(input logic [12:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        req_o.araddr <= a;
        {req_o.arvalid, req_o.rready} <= 2'h3;
        do begin
            @(posedge clk_sys_i);
            n++;
            if (rsp_i.arready) req_o.arvalid <= 1'b0;
        end while (!rsp_i.rvalid && n < 64);
        d = rsp_i.rdata;
        r = rsp_i.rresp;
        req_o.rready <= 1'b0;
        hang(n);
    endtask
endmodule

/* bench/tb.sv */
`timescale 1ns/1ns
module tb;
    logic clk_sys_i = 1'b0;
    logic nrst_i = 1'b0;
    logic soft_rst_i = 1'b0;
    logic fdc_irq = 1'b0;
    logic pp_irq = 1'b0;
    logic s1_irq = 1'b0;
    lcfg_pkg::lcfg_axi_req_s req;
    lcfg_pkg::lcfg_axi_rsp_s rsp;
    logic [lcfg_pkg::IRQ_PINS-1:0] irq;
    logic [lcfg_pkg::IRQ_PINS-1:0] irq_oe;
    logic fdack, fpp, ftri, d0;
    logic [lcfg_pkg::DMA_PINS-1:0] drq, drq_oe;
    logic [31:0] rv;
    logic [1:0] rr;
    int err_count = 0;
    int comparisons = 0;
    initial forever #10 clk_sys_i = ~clk_sys_i;
    lcfg_top dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .soft_rst_i(soft_rst_i),
        .s_axi_req_i(req), .s_axi_rsp_o(rsp), .fdc_irq_req_i(fdc_irq), .fdc_drq_i(fdc_irq),
        .pp_irq_req_i(pp_irq), .pp_ack_n_i(1'b1), .pp_drq_i(1'b0), .ser1_irq_req_i(s1_irq),
        .ser2_irq_req_i(1'b0), .irq_o(irq), .irq_oe_o(irq_oe), .drq_o(drq), .drq_oe_o(drq_oe),
        .fdc_dack_en_o(fdack), .pp_dack_en_o(), .fdd_push_pull_o(fpp),
        .fdd_tristate_o(ftri), .drive0_on_floppy_pins_o(d0), .cfg_o());
    lcfg_host host (.clk_sys_i(clk_sys_i), .req_o(req), .rsp_i(rsp));
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr(input logic [2:0] p, input logic [7:0] i, input logic [31:0] d);
        host.wr({p, i, 2'b00}, d);
    endtask
    task automatic rc(input logic [2:0] p, input logic [7:0] i, input logic [31:0] e);
        host.rd({p, i, 2'b00}, rv, rr);
        chk($sformatf("reg %h.%h", p, i), rv, e);
    endtask
    task automatic ld(input logic [2:0] p, input logic [31:0] sel);
        wr(p, 8'h30, 32'h1);
        wr(p, 8'h70, sel);
    endtask
    // driven pins must also carry the raised request
    task automatic pins(input logic [15:0] e);
        @(posedge clk_sys_i);
        #1;
        chk("irq_oe", irq_oe, e);
        chk("irq", irq & irq_oe, e);
    endtask
    task automatic t_serial;
        ld(3'h3, 32'h3);
        ld(3'h2, 32'h0);
        wr(3'h4, 8'h00, 32'h0C);
        wr(3'h2, 8'hF0, 32'h80);
        @(posedge clk_sys_i);
        s1_irq <= 1'b1;
        pins(16'h0008);
        wr(3'h2, 8'h70, 32'h4);
        pins(16'h0018);
        wr(3'h4, 8'h00, 32'h04);
        pins(16'h0010);
        wr(3'h4, 8'h00, 32'h00);
        pins(16'h0000);
    endtask
    task automatic t_floppy;
        ld(3'h0, 32'h6);
        wr(3'h0, 8'h74, 32'h2);
        wr(3'h4, 8'h00, 32'h1);
        @(posedge clk_sys_i);
        fdc_irq <= 1'b1;
        pins(16'h0040);
        chk("dack", fdack, 32'h1);
        chk("drq", {drq_oe, drq}, 32'h44);
        wr(3'h4, 8'h00, 32'h0);
        pins(16'h0000);
        chk("dack", fdack, 32'h0);
        chk("drq", {drq_oe, drq}, 32'h00);
        wr(3'h4, 8'h00, 32'h3);
        pins(16'h0000);
        wr(3'h4, 8'h00, 32'h1);
        wr(3'h0, 8'h70, 32'h0);
        pins(16'h0000);
    endtask
    task automatic t_pp;
        ld(3'h1, 32'h7);
        wr(3'h4, 8'h00, 32'h00);
        @(posedge clk_sys_i);
        pp_irq <= 1'b1;
        pins(16'h0000);
        wr(3'h4, 8'h00, 32'h10);
        pins(16'h0080);
        wr(3'h1, 8'hF0, 32'h3A);
        for (int m = 0; m < 8; m++) begin
            wr(3'h4, 8'h00, 32'(m) << 6);
            pins((m == 2 || m == 3 || m == 6) ? 16'h0080 : 16'h0000);
        end
        // pulse type: one low drive cycle after the request rises, then float
        wr(3'h1, 8'hF0, 32'hBA);
        pp_irq <= 1'b0;
        wr(3'h4, 8'h00, 32'h80);
        pp_irq <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk("pulse", {irq_oe, irq}, 32'h0080_0000);
        pins(16'h0000);
    endtask
    task automatic t_fields;
        wr(3'h0, 8'hF4, 32'hFF);
        rc(3'h0, 8'hF4, 32'h5B);
        wr(3'h0, 8'hF3, 32'hFF);
        rc(3'h0, 8'hF3, 32'h00);
        wr(3'h2, 8'hF0, 32'hFF);
        rc(3'h2, 8'hF0, 32'h83);
        wr(3'h0, 8'hF0, 32'hFF);
        rc(3'h0, 8'hF0, 32'hCF);
        wr(3'h1, 8'hF1, 32'h01);
        @(posedge clk_sys_i);
        #1;
        chk("pins", {fpp, ftri, d0}, 32'h7);
        host.rd(13'h1C00, rv, rr);
        chk("resp", rr, 32'h2);
    endtask
    task automatic t_soft;
        wr(3'h0, 8'hF0, 32'h05);
        @(posedge clk_sys_i);
        soft_rst_i <= 1'b1;
        @(posedge clk_sys_i);
        soft_rst_i <= 1'b0;
        rc(3'h0, 8'hF0, 32'h05);
    endtask
    task automatic t_hard;
        @(posedge clk_sys_i);
        nrst_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        rc(3'h0, 8'hF0, 32'h0E);
        rc(3'h0, 8'hF2, 32'hFF);
        rc(3'h1, 8'hF0, 32'h3C);
        rc(3'h1, 8'hF1, 32'h00);
        rc(3'h2, 8'hF0, 32'h00);
    endtask
    initial begin
        repeat (6) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        t_serial();
        t_floppy();
        t_pp();
        t_fields();
        t_soft();
        t_hard();
        give_verdict();
    end
endmodule
